/* File: rtl/ssi_params.svh */
// Purpose: constants for the safety status interrupt block
// Assumes: plain register port, byte offsets as printed
// Notes: types live in ssi_pkg
`ifndef SSI_PARAMS_SVH
`define SSI_PARAMS_SVH
`define SSI_ADDR_ENABLE 16'hf050
`define SSI_ADDR_STATUS 16'hf052
`define SSI_ADDR_CLEAR 16'hf054
`define SSI_ADDR_CLEAR_HI 16'hf055
`define SSI_ADDR_MASK 16'hf056
`define SSI_ADDR_LOOPBACK 16'hf058
`define SSI_ADDR_PARITY 16'hf05a
`define SSI_ADDR_CAUSE 16'hf05c
`define SSI_BIT_PARITY 0
`define SSI_BIT_CRC 1
`define SSI_BIT_FLASH 2
`define SSI_BIT_REREQ 15
`define SSI_BIT_PARFLAG 7
`define SSI_BIT_CFGROM 12
`define SSI_SEG_MASK 4'h7
`define SSI_ROM_END 20'h7ffff
`define SSI_START_256K 20'h3ffc0
`define SSI_START_192K 20'h2ffc0
`define SSI_START_160K 20'h27fc0
`define SSI_START_96K 20'h17fc0
`define SSI_START_64K 20'h0ffc0
`define SSI_RESET_PULSE 4'h4
`endif

/* File: rtl/ssi_pkg.sv */
// Purpose: types for the safety status interrupt block
// Assumes: nothing
// Notes: constants sit in ssi_params.svh
package ssi_pkg;
    typedef enum logic [2:0] {
        SSI_MEM_256K = 3'h0,
        SSI_MEM_192K = 3'h1,
        SSI_MEM_160K = 3'h2,
        SSI_MEM_96K = 3'h3,
        SSI_MEM_64K = 3'h4
    } ssi_mem_e;
    typedef enum logic [1:0] {
        SSI_RUN = 2'h0,
        SSI_FIRE = 2'h1,
        SSI_HOLD = 2'h2
    } ssi_rom_e;
endpackage

/* File: rtl/ssi_rom_guard.sv */
// Purpose: watches the fetch address for unused ROM execution
// Assumes: pc and segment come from core logic on core_clk
// Notes: pulse length is a small fixed count
`timescale 1ns/1ns
`include "ssi_params.svh"
module ssi_rom_guard
    import ssi_pkg::*;
#(
    parameter ssi_mem_e MEM_SIZE = SSI_MEM_256K
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic fetchValid,
    input wire logic [3:0] codeSegment,
    input wire logic [15:0] programCounter,
    output logic romReset
);
    typedef struct packed {
        ssi_rom_e state;
        logic [3:0] count;
        logic pulse;
    } ssi_guard_s;
    ssi_guard_s cur;
    ssi_guard_s next_cur;
    logic [19:0] fetchAddr;
    logic [19:0] regionStart;
    logic inRegion;

    always_comb begin
        case (MEM_SIZE)
            SSI_MEM_256K: regionStart = `SSI_START_256K;
            SSI_MEM_192K: regionStart = `SSI_START_192K;
            SSI_MEM_160K: regionStart = `SSI_START_160K;
            SSI_MEM_96K: regionStart = `SSI_START_96K;
            SSI_MEM_64K: regionStart = `SSI_START_64K;
            default: regionStart = `SSI_START_256K;
        endcase
    end

    // segment bit 3 has no meaning, so it is dropped before compare
    assign fetchAddr = {codeSegment & `SSI_SEG_MASK, programCounter};
    assign inRegion = fetchValid && fetchAddr >= regionStart
        && fetchAddr <= `SSI_ROM_END;

    always_comb begin
        next_cur = cur;
        next_cur.pulse = 1'b0;
        case (cur.state)
            SSI_RUN: begin
                if (enable && inRegion) begin
                    next_cur.state = SSI_FIRE;
                    next_cur.count = `SSI_RESET_PULSE;
                    next_cur.pulse = 1'b1;
                end
            end
            SSI_FIRE: begin
                next_cur.pulse = 1'b1;
                next_cur.count = cur.count - 4'h1;
                if (cur.count == 4'h1) begin
                    next_cur.state = SSI_HOLD;
                    next_cur.pulse = 1'b0;
                end
            end
            SSI_HOLD: begin
                // wait for the fetch to leave before arming again
                if (!inRegion) begin
                    next_cur.state = SSI_RUN;
                end
            end
            default: next_cur.state = SSI_RUN;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '{state: SSI_RUN, count: 4'h0, pulse: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign romReset = cur.pulse;
endmodule

/* File: rtl/ssi_safety_irq.sv */
// Purpose: safety event status, enable, clear and request logic
// Assumes: events are one-cycle pulses on core_clk
// Notes: cause flag survives only resets other than reset_n
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`include "ssi_params.svh"
module ssi_safety_irq
    import ssi_pkg::*;
#(
    parameter ssi_mem_e MEM_SIZE = SSI_MEM_256K,
    parameter int NUM_SERIAL = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    input wire logic parityEvent,
    input wire logic crcDoneEvent,
    input wire logic flashDoneEvent,
    output logic safetyRequest,
    output logic irq,
    input wire logic [15:0] configWord0,
    input wire logic fetchValid,
    input wire logic [3:0] codeSegment,
    input wire logic [15:0] programCounter,
    output logic chipReset,
    input wire logic [NUM_SERIAL-1:0] serialTx,
    input wire logic [NUM_SERIAL-1:0] serialRxPin,
    input wire logic [NUM_SERIAL-1:0] portAltFunc,
    output logic [NUM_SERIAL-1:0] serialRx,
    output logic [NUM_SERIAL-1:0] serialTxPin
);
    if (NUM_SERIAL < 1 || NUM_SERIAL > 16) begin : g_bad_serial
        $error("NUM_SERIAL must be 1 to 16");
    end

    typedef struct packed {
        logic [2:0] enable;
        logic [2:0] status;
        logic [2:0] mask;
        logic parityFlag;
        logic causeRom;
        logic romEnable;
        logic cfgLoaded;
        logic request;
        logic irq;
        logic chipReset;
        logic [15:0] loopback;
        logic [15:0] rdata;
        logic [NUM_SERIAL-1:0] rx;
        logic [NUM_SERIAL-1:0] txPin;
        logic [NUM_SERIAL-1:0] rxSync1;
        logic [NUM_SERIAL-1:0] rxSync2;
    } ssi_state_s;
    ssi_state_s cur;
    ssi_state_s next_cur;
    logic romReset;
    logic [2:0] events;
    logic [2:0] clearBits;
    logic [2:0] setBits;
    logic reRequest;
    logic newEvent;
    wire [NUM_SERIAL-1:0] loopRx;
    wire [NUM_SERIAL-1:0] pinDrive;

    ssi_rom_guard #(
        .MEM_SIZE(MEM_SIZE)
    ) u_guard (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .enable(cur.romEnable),
        .fetchValid(fetchValid),
        .codeSegment(codeSegment),
        .programCounter(programCounter),
        .romReset(romReset)
    );

    assign events = {flashDoneEvent, crcDoneEvent, parityEvent};
    assign clearBits = (regWrite && regAddr == `SSI_ADDR_CLEAR)
        ? regWdata[2:0] : 3'h0;
    assign reRequest = regWrite && ((regAddr == `SSI_ADDR_CLEAR
        && regWdata[`SSI_BIT_REREQ])
        || (regAddr == `SSI_ADDR_CLEAR_HI && regWdata[7]));
    // an event only sets its status bit when its enable is set; parityFlag is set regardless
    assign setBits = events & cur.enable;
    assign newEvent = |setBits;

    always_comb begin
        next_cur = cur;
        next_cur.request = 1'b0;
        next_cur.rdata = 16'h0;
        // set wins over a clear arriving in the same cycle
        next_cur.status = (cur.status & ~clearBits) | setBits;
        // of the events, only a first one from an all-zero status requests; a rerequest write also requests while status is non-zero
        if (newEvent && cur.status == 3'h0) begin
            next_cur.request = 1'b1;
        end
        if (reRequest && cur.status != 3'h0) begin
            next_cur.request = 1'b1;
        end
        if (parityEvent) begin
            next_cur.parityFlag = 1'b1;
        end else if (regWrite && regAddr == `SSI_ADDR_PARITY
                && regWdata[`SSI_BIT_PARFLAG]) begin
            next_cur.parityFlag = 1'b0;
        end
        // strap is caught once after reset release
        if (!cur.cfgLoaded) begin
            next_cur.cfgLoaded = 1'b1;
            next_cur.romEnable = configWord0[`SSI_BIT_CFGROM];
        end
        if (romReset) begin
            next_cur.causeRom = 1'b1;
        end else if (regWrite && regAddr == `SSI_ADDR_CAUSE
                && regWdata[0]) begin
            next_cur.causeRom = 1'b0;
        end
        next_cur.chipReset = romReset;
        if (regWrite) begin
            case (regAddr)
                `SSI_ADDR_ENABLE: next_cur.enable = regWdata[2:0];
                `SSI_ADDR_MASK: next_cur.mask = regWdata[2:0];
                `SSI_ADDR_LOOPBACK: next_cur.loopback = regWdata;
                default: ;
            endcase
        end
        if (regRead) begin
            case (regAddr)
                `SSI_ADDR_ENABLE: next_cur.rdata = {13'h0, cur.enable};
                `SSI_ADDR_STATUS: next_cur.rdata = {13'h0, cur.status};
                `SSI_ADDR_CLEAR: next_cur.rdata = 16'h0;
                `SSI_ADDR_MASK: next_cur.rdata = {13'h0, cur.mask};
                `SSI_ADDR_LOOPBACK: next_cur.rdata = cur.loopback;
                `SSI_ADDR_PARITY:
                    next_cur.rdata = {8'h0, cur.parityFlag, 7'h0};
                `SSI_ADDR_CAUSE: next_cur.rdata = {15'h0, cur.causeRom};
                default: next_cur.rdata = 16'h0;
            endcase
        end
        next_cur.irq = |(next_cur.status & cur.mask);
        next_cur.rxSync1 = serialRxPin;
        next_cur.rxSync2 = cur.rxSync1;
        next_cur.rx = loopRx;
        next_cur.txPin = pinDrive;
    end

    // loopback per serial unit; pin drive still follows port function
    for (genvar i = 0; i < NUM_SERIAL; i++) begin : g_loop
        assign loopRx[i] = cur.loopback[i] ? serialTx[i]
            : cur.rxSync2[i];
        assign pinDrive[i] = portAltFunc[i] & serialTx[i];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
            cur.txPin <= '1;
            cur.rx <= '1;
        end else begin
            cur <= next_cur;
        end
    end

    assign regRdata = cur.rdata;
    assign safetyRequest = cur.request;
    assign irq = cur.irq;
    assign chipReset = cur.chipReset;
    assign serialRx = cur.rx;
    assign serialTxPin = cur.txPin;
endmodule

/* File: tb/ssi_safety_irq_sva.sv */
// Purpose: port assertions for ssi_safety_irq
// Assumes: MEM_SIZE at 256K, configWord0 steady between resets
// Notes: status is internal, so outputs are tied to bus and events
`timescale 1ns/1ns
`include "ssi_params.svh"
module ssi_safety_irq_sva #(
    parameter int NUM_SERIAL = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic parityEvent,
    input wire logic crcDoneEvent,
    input wire logic flashDoneEvent,
    input wire logic safetyRequest,
    input wire logic irq,
    input wire logic [15:0] configWord0,
    input wire logic fetchValid,
    input wire logic [3:0] codeSegment,
    input wire logic [15:0] programCounter,
    input wire logic chipReset,
    input wire logic [NUM_SERIAL-1:0] serialTx,
    input wire logic [NUM_SERIAL-1:0] portAltFunc,
    input wire logic [NUM_SERIAL-1:0] serialTxPin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire anyEv = parityEvent | crcDoneEvent | flashDoneEvent;
    wire clrWr = regWrite && regAddr == `SSI_ADDR_CLEAR;
    wire reqWr = (clrWr && regWdata[`SSI_BIT_REREQ])
        || (regWrite && regAddr == `SSI_ADDR_CLEAR_HI && regWdata[7]);
    wire maskWr = regWrite && regAddr == `SSI_ADDR_MASK;
    // segment bit 3 dropped before the compare
    wire [19:0] fetchAddr = {1'b0, codeSegment[2:0], programCounter};
    wire romHit = fetchValid && configWord0[`SSI_BIT_CFGROM]
        && fetchAddr >= `SSI_START_256K;
    sequence rstPulse;
        chipReset [*4] ##1 !chipReset;
    endsequence
    clr_reads_zero_a: assert property (
        regRead && regAddr == `SSI_ADDR_CLEAR |=> regRdata == 16'h0000)
        else $error("clear register read not zero");
    req_one_pulse_a: assert property (
        safetyRequest |=> !safetyRequest)
        else $error("request longer than one cycle");
    req_cause_a: assert property (
        safetyRequest |-> $past(anyEv || reqWr))
        else $error("request without event or rerequest");
    rereq_zero_a: assert property (
        clrWr && !regWdata[`SSI_BIT_REREQ] && !anyEv |=> !safetyRequest)
        else $error("request after zero rerequest bit");
    rom_pulse_a: assert property (
        $rose(chipReset) |-> rstPulse)
        else $error("chip reset pulse length wrong");
    rom_cause_a: assert property (
        $rose(chipReset) |-> $past(romHit) || $past(romHit, 2))
        else $error("chip reset without unused region fetch");
    pin_drive_a: assert property (
        $past(reset_n) |-> serialTxPin == $past(portAltFunc & serialTx))
        else $error("transmit pin drive wrong");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(anyEv || maskWr) || $past(anyEv || maskWr, 2))
        else $error("interrupt rose without cause");
endmodule
bind ssi_safety_irq ssi_safety_irq_sva #(.NUM_SERIAL(NUM_SERIAL)) chk (.*);

/* File: tb/ssi_intc_model.sv */
// Purpose: interrupt controller stand-in that counts requests
// Assumes: safetyRequest is a one-cycle pulse
// Notes: a held level counts once per cycle, so stretching shows up
`timescale 1ns/1ns
module ssi_intc_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic safetyRequest,
    output int reqCount
);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reqCount <= 0;
        end else if (safetyRequest) begin
            reqCount <= reqCount + 1;
        end
    end
endmodule

/* File: tb/ssi_safety_irq_tb_top.sv */
// Purpose: scenario bench for ssi_safety_irq
// Assumes: MEM_SIZE default, NUM_SERIAL 16
// Notes: software duties are played by the register tasks
`timescale 1ns/1ns
`include "ssi_params.svh"
module ssi_safety_irq_tb_top;
    logic core_clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
    logic parityEvent = 0, crcDoneEvent = 0, flashDoneEvent = 0;
    logic fetchValid = 0, safetyRequest, irq, chipReset;
    logic [3:0] codeSegment = 4'h0;
    logic [15:0] regAddr = 0, regWdata = 0, programCounter = 0;
    logic [15:0] configWord0 = 16'hffff, serialTx = 0, portAltFunc = 0;
    logic [15:0] serialRxPin = 16'h5555;
    logic [15:0] regRdata, serialRx, serialTxPin;
    int reqCount, fail_count = 0, num_checks = 0, cycles = 0;
    ssi_safety_irq dut (.*);
    ssi_intc_model intc (.*);
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    task check(input logic [15:0] seen, want);
        num_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task wr(input logic [15:0] a, d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1;
        @(posedge core_clk);
        regWrite <= 0;
    endtask
    task rd(input logic [15:0] a, want);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1;
        @(posedge core_clk);
        regRead <= 0;
        @(negedge core_clk);
        check(regRdata, want);
    endtask
    task ev(input logic [2:0] m);
        @(posedge core_clk);
        {flashDoneEvent, crcDoneEvent, parityEvent} <= m;
        @(posedge core_clk);
        {flashDoneEvent, crcDoneEvent, parityEvent} <= 3'h0;
        tick(2);
    endtask
    task rst(input logic [15:0] cfg);
        configWord0 <= cfg;
        reset_n <= 0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1;
    endtask
    task t_regs;
        rd(`SSI_ADDR_ENABLE, 0);
        rd(`SSI_ADDR_STATUS, 0);
        wr(`SSI_ADDR_STATUS, 16'h0007);
        rd(`SSI_ADDR_STATUS, 0);
        wr(`SSI_ADDR_ENABLE, 16'h00ff);
        rd(`SSI_ADDR_ENABLE, 16'h0007);
        rd(`SSI_ADDR_CLEAR, 0);
        rd(16'hf0f0, 0);
        $display("test regs done");
    endtask
    task t_events;
        int n;
        n = reqCount;
        wr(`SSI_ADDR_MASK, 16'h0007);
        ev(3'h1);
        check(16'(reqCount - n), 16'h1);
        check(16'(irq), 16'h1);
        ev(3'h2);
        check(16'(reqCount - n), 16'h1);
        rd(`SSI_ADDR_STATUS, 16'h0003);
        rd(`SSI_ADDR_PARITY, 16'h0080);
        wr(`SSI_ADDR_PARITY, 16'h0000);
        rd(`SSI_ADDR_PARITY, 16'h0080);
        wr(`SSI_ADDR_PARITY, 16'h0080);
        rd(`SSI_ADDR_PARITY, 16'h0000);
        wr(`SSI_ADDR_CLEAR, 16'h0001);
        rd(`SSI_ADDR_STATUS, 16'h0002);
        wr(`SSI_ADDR_CLEAR, 16'h0000);
        rd(`SSI_ADDR_STATUS, 16'h0002);
        wr(`SSI_ADDR_CLEAR, 16'h8000);
        tick(2);
        check(16'(reqCount - n), 16'h2);
        wr(`SSI_ADDR_CLEAR, 16'h0006);
        rd(`SSI_ADDR_STATUS, 0);
        check(16'(irq), 16'h0);
        wr(`SSI_ADDR_CLEAR, 16'h8000);
        tick(2);
        check(16'(reqCount - n), 16'h2);
        wr(`SSI_ADDR_ENABLE, 16'h0004);
        ev(3'h3);
        rd(`SSI_ADDR_STATUS, 0);
        ev(3'h4);
        check(16'(reqCount - n), 16'h3);
        rd(`SSI_ADDR_STATUS, 16'h0004);
        wr(`SSI_ADDR_MASK, 16'h0003);
        tick(2);
        check(16'(irq), 16'h0);
        $display("test events done");
    endtask
    task t_loop;
        wr(`SSI_ADDR_LOOPBACK, 16'h0001);
        portAltFunc <= 16'h0002;
        serialTx <= 16'h0003;
        tick(3);
        check(serialRx & 16'h0003, 16'h0001);
        check(serialTxPin, 16'h0002);
        serialTx <= 16'h0000;
        tick(1);
        check(serialRx & 16'h0003, 16'h0000);
        $display("test loopback done");
    endtask
    task t_rom;
        fetchValid <= 1;
        codeSegment <= 4'hb;
        programCounter <= 16'hffbf;
        tick(4);
        check(16'(chipReset), 16'h0);
        programCounter <= 16'hffc0;
        tick(3);
        check(16'(chipReset), 16'h1);
        fetchValid <= 0;
        tick(6);
        rd(`SSI_ADDR_CAUSE, 16'h0001);
        wr(`SSI_ADDR_CAUSE, 16'h0001);
        rd(`SSI_ADDR_CAUSE, 16'h0000);
        rst(16'hefff);
        fetchValid <= 1;
        tick(6);
        check(16'(chipReset), 16'h0);
        fetchValid <= 0;
        $display("test rom done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst(16'hffff);
        t_regs();
        t_events();
        t_loop();
        t_rom();
        finish_test();
    end
endmodule
